/* File: rtl/power_stage_pwm_control.sv */
// Purpose: Register file, counter, compare and fault handling of a three-module PWM stage.
// Assumes: 8-bit register port with read data one cycle after the read strobe.
// Notes:   PLL and I/O clocks arrive as enable pulses; outputs are gated A/B per module.
// Functional notes
// - Four 12-bit compares per module against counter.
// - High byte held, committed with low byte.
// - Lock set defers shadow compare/config updates.
// - Mode bit: ramp or centre-aligned counting.
// - B polarity: clear low, set high.
// - A polarity: clear low, set high.
// - Prescaler divides by 1, 4, 32, 256.
// - Clock select: PLL when set, else I/O.
// - Complete-cycle bit finishes cycle before halting.
// - Run bit starts; clearing requests halt.
// - Reserved bits read as zero.
// - Overlap disable bit removes A/B protection.
// - Source select: pin or comparator.
// - Level bit picks significant fault level.
// - Filter needs four equal samples.
// - Async bit clear: fault kills outputs directly.
// - Mode field chooses fault input action.
// - Event enables gate fault interrupt request.
// - Cycle-end enable gates end interrupt request.
// - Hardware sets event flag; one clears.
// - Flags set regardless of enables.
// - Halt-and-wait resumes only on run set.
// - Cycle end is the compare_rb match.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module power_stage_pwm_control (
	input  wire logic                                 clock,
	input  wire logic                                 rst,
	input  wire logic [pwm_stage_pkg::ADDR_W-1:0]     addr,
	input  wire logic [pwm_stage_pkg::DATA_W-1:0]     wdata,
	input  wire logic                                 wr_en,
	input  wire logic                                 rd_en,
	output logic      [pwm_stage_pkg::DATA_W-1:0]     rdata,
	input  wire logic                                 pll_tick,
	input  wire logic                                 io_tick,
	input  wire logic [pwm_stage_pkg::MODULES-1:0]    fault_input_pin,
	input  wire logic [pwm_stage_pkg::MODULES-1:0]    comparator_in,
	output logic      [pwm_stage_pkg::MODULES-1:0]    out_a,
	output logic      [pwm_stage_pkg::MODULES-1:0]    out_b,
	output logic                                      fault_irq,
	output logic                                      cycle_end_irq,
	output logic                                      running
);
	localparam int M = pwm_stage_pkg::MODULES;
	localparam int W = pwm_stage_pkg::CMP_W;

	logic [7:0]   temp_hi_r;
	logic [W-1:0] cmp_r     [M][4];
	logic [W-1:0] cmp_act_r [M][4];
	logic [7:0]   outcfg_r, outcfg_act_r;
	logic [7:0]   ctrl_r;
	logic [7:0]   mic_r     [M];
	logic [7:0]   mask_r;
	logic [7:0]   flag_r;
	logic [7:0]   rdata_r;
	logic [7:0]   pre_cnt_r;
	logic [W-1:0] cnt_r;
	logic         down_r;
	logic [M-1:0] fault_raw, fault_act, fault_act_d_r;
	logic [M-1:0] wave_a_r, wave_b_r;
	logic [M-1:0] kill_a, kill_b;
	logic         kill_all, halt_req;
	logic         pwm_tick, cycle_end;
	logic [1:0]   tick_sync_r;
	pwm_stage_pkg::run_state_t state_r, state_nxt;

	// Decode a compare byte address into module, slot and byte half.
	function automatic logic cmp_hit(input logic [5:0] a, output logic [1:0] m,
		output logic [1:0] s, output logic hi);
		logic [5:0] off;
		m   = 2'(a / pwm_stage_pkg::MODULE_STEP);
		off = a % pwm_stage_pkg::MODULE_STEP;
		s   = off[2:1];
		hi  = off[0];
		return a < pwm_stage_pkg::MIC_BASE;
	endfunction

	// Action field decode; shared by kill and halt logic.
	function automatic logic [2:0] action(input logic [7:0] mic);
		return mic[2:0];
	endfunction

	// Register writes; locked changes stay in the software copy.
	always_ff @(posedge clock or posedge rst) begin
		logic [1:0] m, s;
		logic       hi, hit;
		if (rst) begin
			temp_hi_r <= 8'h00;
			outcfg_r  <= 8'h00;
			mask_r    <= 8'h00;
			for (int i = 0; i < M; i++) begin
				mic_r[i] <= 8'h00;
				for (int j = 0; j < 4; j++) cmp_r[i][j] <= '0;
			end
		end else begin
			hit = cmp_hit(addr, m, s, hi);
			if (wr_en && hit && int'(m) < M) begin
				if (hi) begin
					temp_hi_r <= wdata;
				end else begin
					cmp_r[m][s] <= {temp_hi_r[W-9:0], wdata};
				end
			end
			if (wr_en && addr >= pwm_stage_pkg::MIC_BASE && addr < pwm_stage_pkg::MIC_BASE + 6'(M))
				mic_r[2'(addr - pwm_stage_pkg::MIC_BASE)] <= wdata;
			if (wr_en && addr == pwm_stage_pkg::OUTCFG_ADDR)
				outcfg_r <= wdata & pwm_stage_pkg::OC_MASK;
			if (wr_en && addr == pwm_stage_pkg::MASK_ADDR)
				mask_r <= wdata & pwm_stage_pkg::MASK_BITS;
		end
	end

	// Running copies follow the software copies only while unlocked.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			outcfg_act_r <= 8'h00;
			for (int i = 0; i < M; i++)
				for (int j = 0; j < 4; j++) cmp_act_r[i][j] <= '0;
		end else if (!outcfg_r[pwm_stage_pkg::OC_LOCK]) begin
			outcfg_act_r <= outcfg_r;
			cmp_act_r    <= cmp_r;
		end
	end

	// Control register: run bit also cleared by hardware on halt.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_r <= 8'h00;
		end else if (wr_en && addr == pwm_stage_pkg::CTRL_ADDR) begin
			ctrl_r <= wdata & pwm_stage_pkg::CT_MASK;
		end else if (state_r == pwm_stage_pkg::ST_FAULT && state_nxt == pwm_stage_pkg::ST_FAULT
			&& halt_req) begin
			ctrl_r[pwm_stage_pkg::CT_RUN] <= 1'b0;
		end
	end

	// Selected clock and prescaler make the counting tick.
	always_ff @(posedge clock or posedge rst) begin
		logic src;
		logic [7:0] lim;
		if (rst) begin
			tick_sync_r <= 2'h0;
			pre_cnt_r   <= 8'h00;
		end else begin
			src = ctrl_r[pwm_stage_pkg::CT_CLKSEL] ? pll_tick : io_tick;
			tick_sync_r <= {tick_sync_r[0], src};
			case (ctrl_r[pwm_stage_pkg::CT_PRE_HI:pwm_stage_pkg::CT_PRE_LO])
				2'h1:    lim = pwm_stage_pkg::DIV_4;
				2'h2:    lim = pwm_stage_pkg::DIV_32;
				2'h3:    lim = pwm_stage_pkg::DIV_256;
				default: lim = 8'h00;
			endcase
			if (state_r == pwm_stage_pkg::ST_IDLE) pre_cnt_r <= 8'h00;
			else if (src) pre_cnt_r <= (pre_cnt_r >= lim) ? 8'h00 : pre_cnt_r + 8'h01;
		end
	end

	always_comb begin
		logic [7:0] lim2;
		lim2 = 8'h00;
		case (ctrl_r[pwm_stage_pkg::CT_PRE_HI:pwm_stage_pkg::CT_PRE_LO])
			2'h1:    lim2 = pwm_stage_pkg::DIV_4;
			2'h2:    lim2 = pwm_stage_pkg::DIV_32;
			2'h3:    lim2 = pwm_stage_pkg::DIV_256;
			default: lim2 = 8'h00;
		endcase
		pwm_tick = (ctrl_r[pwm_stage_pkg::CT_CLKSEL] ? pll_tick : io_tick)
			&& pre_cnt_r >= lim2 && (state_r == pwm_stage_pkg::ST_RUN
			|| state_r == pwm_stage_pkg::ST_DRAIN);
	end

	// Module 0 compare_rb sets the period; its match ends the cycle.
	assign cycle_end = pwm_tick && cnt_r == cmp_act_r[0][3] && !down_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r  <= '0;
			down_r <= 1'b0;
		end else if (state_r == pwm_stage_pkg::ST_IDLE) begin
			cnt_r  <= '0;
			down_r <= 1'b0;
		end else if (pwm_tick) begin
			if (!outcfg_act_r[pwm_stage_pkg::OC_MODE]) begin
				cnt_r <= (cnt_r >= cmp_act_r[0][3]) ? '0 : cnt_r + 1'b1;
			end else if (!down_r) begin
				if (cnt_r >= cmp_act_r[0][3]) down_r <= 1'b1;
				else cnt_r <= cnt_r + 1'b1;
			end else begin
				if (cnt_r == '0) down_r <= 1'b0;
				else cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	// Waveforms: A high from SA to RA, B from SB to RB, per module.
	generate
		for (genvar g = 0; g < M; g++) begin : g_mod
			fault_input_cond u_cond (
				.clock               (clock),
				.rst                 (rst),
				.fault_input_pin     (fault_input_pin[g]),
				.comparator_in       (comparator_in[g]),
				.input_source_select (mic_r[g][pwm_stage_pkg::MI_SRC]),
				.input_level_select  (mic_r[g][pwm_stage_pkg::MI_LEVEL]),
				.input_filter_enable (mic_r[g][pwm_stage_pkg::MI_FILT]),
				.fault_raw           (fault_raw[g]),
				.fault_active        (fault_act[g])
			);
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					wave_a_r[g] <= 1'b0;
					wave_b_r[g] <= 1'b0;
				end else if (state_r == pwm_stage_pkg::ST_IDLE) begin
					wave_a_r[g] <= 1'b0;
					wave_b_r[g] <= 1'b0;
				end else if (pwm_tick) begin
					if (cnt_r == cmp_act_r[g][1]) wave_a_r[g] <= 1'b1;
					if (cnt_r == cmp_act_r[g][0]) wave_a_r[g] <= 1'b0;
					if (cnt_r == cmp_act_r[g][2]) wave_b_r[g] <= 1'b1;
					if (cnt_r == cmp_act_r[g][3]) wave_b_r[g] <= 1'b0;
				end
			end
			always_comb begin
				logic a_on, b_on, ovl, direct;
				ovl    = mic_r[g][pwm_stage_pkg::MI_OVL];
				direct = !mic_r[g][pwm_stage_pkg::MI_ASYNC] && fault_raw[g];
				a_on   = wave_a_r[g] && !kill_a[g] && !direct;
				b_on   = wave_b_r[g] && !kill_b[g] && !direct;
				if (!ovl && a_on && b_on) b_on = 1'b0;
				out_a[g] = outcfg_act_r[pwm_stage_pkg::OC_POLA] ? a_on : !a_on;
				out_b[g] = outcfg_act_r[pwm_stage_pkg::OC_POLB] ? b_on : !b_on;
			end
		end
	endgenerate

	// Fault actions by input mode.
	always_comb begin
		kill_all = 1'b0;
		halt_req = 1'b0;
		for (int i = 0; i < M; i++) begin
			if (fault_act[i] && action(mic_r[i])[2:1] == 2'b10) kill_all = 1'b1;
			if (fault_act[i] && action(mic_r[i])[2:1] == 2'b11) halt_req = 1'b1;
		end
		for (int i = 0; i < M; i++) begin
			kill_a[i] = kill_all || (fault_act[i] && action(mic_r[i]) inside {3'h1, 3'h3});
			kill_b[i] = kill_all || (fault_act[i] && action(mic_r[i]) inside {3'h2, 3'h3});
		end
	end

	// Run state: halt at once or after the current cycle.
	always_comb begin
		logic run;
		run       = ctrl_r[pwm_stage_pkg::CT_RUN];
		state_nxt = state_r;
		case (state_r)
			pwm_stage_pkg::ST_IDLE:  if (run) state_nxt = pwm_stage_pkg::ST_RUN;
			pwm_stage_pkg::ST_RUN: begin
				if (halt_req) state_nxt = pwm_stage_pkg::ST_FAULT;
				else if (!run && ctrl_r[pwm_stage_pkg::CT_CCYC]) state_nxt = pwm_stage_pkg::ST_DRAIN;
				else if (!run) state_nxt = pwm_stage_pkg::ST_IDLE;
			end
			pwm_stage_pkg::ST_DRAIN: begin
				if (halt_req) state_nxt = pwm_stage_pkg::ST_FAULT;
				else if (cycle_end) state_nxt = pwm_stage_pkg::ST_IDLE;
			end
			pwm_stage_pkg::ST_FAULT: begin
				if (wr_en && addr == pwm_stage_pkg::CTRL_ADDR && wdata[pwm_stage_pkg::CT_RUN])
					state_nxt = pwm_stage_pkg::ST_RUN;
			end
			default: state_nxt = pwm_stage_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) state_r <= pwm_stage_pkg::ST_IDLE;
		else state_r <= state_nxt;
	end

	// Flags: a new event wins over a same-cycle write-one clear.
	always_ff @(posedge clock or posedge rst) begin
		logic [7:0] set, clr;
		if (rst) begin
			flag_r        <= 8'h00;
			fault_act_d_r <= '0;
		end else begin
			fault_act_d_r <= fault_act;
			set = 8'h00;
			for (int i = 0; i < M; i++)
				set[i+1] = fault_act[i] && !fault_act_d_r[i] && action(mic_r[i]) != 3'h0;
			set[pwm_stage_pkg::FLAG_EOC] = cycle_end;
			clr = (wr_en && addr == pwm_stage_pkg::FLAG_ADDR) ? wdata : 8'h00;
			flag_r <= ((flag_r & ~clr) | set) & pwm_stage_pkg::FLAG_BITS;
		end
	end

	assign fault_irq     = |(flag_r[3:1] & mask_r[3:1]);
	assign cycle_end_irq = flag_r[pwm_stage_pkg::FLAG_EOC] && mask_r[pwm_stage_pkg::FLAG_EOC];
	assign running       = state_r == pwm_stage_pkg::ST_RUN || state_r == pwm_stage_pkg::ST_DRAIN;

	// Read port: compare reads return the live software copy.
	always_ff @(posedge clock or posedge rst) begin
		logic [1:0] m, s;
		logic       hi, hit;
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (rd_en) begin
			hit = cmp_hit(addr, m, s, hi);
			rdata_r <= 8'h00;
			if (hit && int'(m) < M)
				rdata_r <= hi ? {4'h0, cmp_r[m][s][W-1:8]} : cmp_r[m][s][7:0];
			else if (addr >= pwm_stage_pkg::MIC_BASE && addr < pwm_stage_pkg::MIC_BASE + 6'(M))
				rdata_r <= mic_r[2'(addr - pwm_stage_pkg::MIC_BASE)];
			else if (addr == pwm_stage_pkg::OUTCFG_ADDR) rdata_r <= outcfg_r;
			else if (addr == pwm_stage_pkg::CTRL_ADDR)   rdata_r <= ctrl_r;
			else if (addr == pwm_stage_pkg::MASK_ADDR)   rdata_r <= mask_r;
			else if (addr == pwm_stage_pkg::FLAG_ADDR)   rdata_r <= flag_r;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign rdata = rdata_r;
endmodule
`default_nettype wire

/* File: rtl/pwm_stage_pkg.sv */
// Purpose: Shared constants for the three-module power stage PWM controller.
// Assumes: 8-bit register port, one clock, registers at byte offsets below.
// Notes:   Offsets are chosen for this block; compare words use the shared high-byte holder.
package pwm_stage_pkg;
	localparam int          MODULES      = 3;
	localparam int          CMP_W        = 12;
	localparam int          ADDR_W       = 6;
	localparam int          DATA_W       = 8;
	// Compare pairs: module n uses base 8*n; low byte at +0, high byte at +1.
	localparam logic [5:0]  CMP_RA_LO    = 6'h00;
	localparam logic [5:0]  CMP_SA_LO    = 6'h02;
	localparam logic [5:0]  CMP_SB_LO    = 6'h04;
	localparam logic [5:0]  CMP_RB_LO    = 6'h06;
	localparam logic [5:0]  MODULE_STEP  = 6'h08;
	localparam logic [5:0]  MIC_BASE     = 6'h18;
	localparam logic [5:0]  OUTCFG_ADDR  = 6'h1C;
	localparam logic [5:0]  CTRL_ADDR    = 6'h1D;
	localparam logic [5:0]  MASK_ADDR    = 6'h1E;
	localparam logic [5:0]  FLAG_ADDR    = 6'h1F;
	// Output configuration fields.
	localparam int          OC_LOCK      = 5;
	localparam int          OC_MODE      = 4;
	localparam int          OC_POLB      = 3;
	localparam int          OC_POLA      = 2;
	localparam logic [7:0]  OC_MASK      = 8'h3C;
	// Control fields.
	localparam int          CT_PRE_HI    = 7;
	localparam int          CT_PRE_LO    = 6;
	localparam int          CT_CLKSEL    = 5;
	localparam int          CT_CCYC      = 1;
	localparam int          CT_RUN       = 0;
	localparam logic [7:0]  CT_MASK      = 8'hE3;
	// Module input control fields.
	localparam int          MI_OVL       = 7;
	localparam int          MI_SRC       = 6;
	localparam int          MI_LEVEL     = 5;
	localparam int          MI_FILT      = 4;
	localparam int          MI_ASYNC     = 3;
	localparam logic [7:0]  MASK_BITS    = 8'h0F;
	localparam logic [7:0]  FLAG_BITS    = 8'h0F;
	localparam int          FLAG_EOC     = 0;
	// Prescale divide figures and filter depth.
	localparam logic [7:0]  DIV_4        = 8'h03;
	localparam logic [7:0]  DIV_32       = 8'h1F;
	localparam logic [7:0]  DIV_256      = 8'hFF;
	localparam int          FILT_SAMPLES = 4;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_DRAIN = 2'b11,
		ST_FAULT = 2'b10
	} run_state_t;
endpackage

/* File: rtl/fault_input_cond.sv */
// Purpose: Conditions one module fault input: sync, optional noise filter, level select.
// Assumes: Pin and comparator inputs are asynchronous to clock.
// Notes:   The raw selected level is also offered for the asynchronous output kill path.
`timescale 1ns/10ps
`default_nettype none
module fault_input_cond (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic fault_input_pin,
	input  wire logic comparator_in,
	input  wire logic input_source_select,
	input  wire logic input_level_select,
	input  wire logic input_filter_enable,
	output logic      fault_raw,
	output logic      fault_active
);
	logic [1:0] sync_r;
	logic [pwm_stage_pkg::FILT_SAMPLES-1:0] hist_r;
	logic       filt_r;
	logic       sel_raw;

	assign sel_raw   = input_source_select ? comparator_in : fault_input_pin;
	assign fault_raw = (sel_raw == input_level_select);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_r <= 2'h0;
		end else begin
			sync_r <= {sync_r[0], sel_raw};
		end
	end

	// Filter holds its output until four equal samples in a row agree.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hist_r <= '0;
			filt_r <= 1'b0;
		end else begin
			hist_r <= {hist_r[pwm_stage_pkg::FILT_SAMPLES-2:0], sync_r[1]};
			if (&hist_r) begin
				filt_r <= 1'b1;
			end else if (~|hist_r) begin
				filt_r <= 1'b0;
			end
		end
	end

	always_comb begin
		if (input_filter_enable) begin
			fault_active = (filt_r == input_level_select);
		end else begin
			fault_active = (sync_r[1] == input_level_select);
		end
	end
endmodule
`default_nettype wire

/* File: testbench/pwm_stage_monitor.sv */
// Purpose: Port checker for the PWM stage register port and status outputs.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes:   Flag state is seen only through reads and the request outputs.
`timescale 1ns/10ps
`default_nettype none
module pwm_stage_monitor (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       fault_irq,
	input wire logic       cycle_end_irq,
	input wire logic       running
);
	localparam logic [5:0] FA = pwm_stage_pkg::FLAG_ADDR;
	localparam logic [5:0] CA = pwm_stage_pkg::CTRL_ADDR;
	localparam logic [5:0] OA = pwm_stage_pkg::OUTCFG_ADDR;
	localparam logic [5:0] MA = pwm_stage_pkg::MASK_ADDR;
	localparam logic [5:0] MB = pwm_stage_pkg::MIC_BASE;
	default clocking mck @(posedge clock); endclocking
	default disable iff (rst);
	rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data outside a read answer");
	flag_resv_a: assert property (rd_en && addr == FA |=> rdata[7:4] == 4'h0)
		else $error("flag reserved bits set");
	ctrl_resv_a: assert property (rd_en && addr == CA |=> rdata[4:2] == 3'h0)
		else $error("control reserved bits set");
	cfg_resv_a: assert property (rd_en && addr == OA |=> (rdata & 8'hC3) == 8'h00)
		else $error("output config reserved bits set");
	mask_resv_a: assert property (rd_en && addr == MA |=> rdata[7:4] == 4'h0)
		else $error("mask reserved bits set");
	cmp_high_a: assert property (rd_en && addr < MB && addr[0] |=> rdata[7:4] == 4'h0)
		else $error("compare high byte wider than 12 bits");
	run_start_a: assert property (wr_en && addr == CA && wdata[0] |-> ##[1:2] running)
		else $error("run write did not start");
	run_stop_a: assert property (wr_en && addr == CA && wdata[1:0] == 2'h0 |-> ##[1:2] !running)
		else $error("plain halt did not stop");
	drain_keep_a: assert property (wr_en && addr == CA && wdata[1:0] == 2'h2 && running
		|=> running [*2])
		else $error("complete-cycle halt stopped at once");
	end_flag_a: assert property (rd_en && addr == FA && cycle_end_irq |=> rdata[0])
		else $error("end request without end flag");
	fault_flag_a: assert property (rd_en && addr == FA && fault_irq |=> rdata[3:1] != 3'h0)
		else $error("fault request without event flag");
	flag_keep_a: assert property (wr_en && addr == FA && wdata == 8'h00 && cycle_end_irq
		|=> cycle_end_irq)
		else $error("zero write cleared a flag");
	cover property (wr_en && addr == CA && wdata[1:0] == 2'h2 && running);
	cover property (fault_irq);
	cover property (cycle_end_irq && running);
endmodule
bind power_stage_pwm_control pwm_stage_monitor mon (.clock(clock), .rst(rst), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fault_irq(fault_irq),
	.cycle_end_irq(cycle_end_irq), .running(running));
`default_nettype wire

/* File: testbench/fault_source_model.sv */
// Purpose: Far-side model: clock source ticks and fault line drivers.
// Assumes: Tick pulses share the system clock; fault lines idle low.
// Notes:   The slow source ticks once every IO_GAP cycles, so waveforms stretch.
`timescale 1ns/10ps
`default_nettype none
module fault_source_model #(
	parameter int IO_GAP = 4
) (
	input  wire logic       clock,
	output logic            pll_tick,
	output logic            io_tick,
	output logic      [2:0] fault_input_pin,
	output logic      [2:0] comparator_in
);
	int gap_cnt;
	initial begin
		pll_tick        = 1'b0;
		io_tick         = 1'b0;
		fault_input_pin = 3'h0;
		comparator_in   = 3'h0;
		gap_cnt         = 0;
	end
	always @(posedge clock) begin
		pll_tick <= 1'b1;
		io_tick  <= (gap_cnt == 0);
		gap_cnt  <= (gap_cnt + 1) % IO_GAP;
	end
	task automatic drive(int n, bit c, bit v);
		@(posedge clock);
		if (c)
			comparator_in[n] <= v;
		else
			fault_input_pin[n] <= v;
	endtask
endmodule
`default_nettype wire

/* File: testbench/power_stage_pwm_control_bench.sv */
// Purpose: Self-checking bench for the three-module PWM stage register block.
// Assumes: Expected values come from the register layout, not from the design.
// Notes:   Outputs are judged at the falling edge, after launch edges settle.
`timescale 1ns/10ps
`default_nettype none
module power_stage_pwm_control_bench;
	typedef struct {
		string      what;
		logic [7:0] val;
	} note_t;
	localparam logic [5:0] FA = pwm_stage_pkg::FLAG_ADDR;
	localparam logic [5:0] CA = pwm_stage_pkg::CTRL_ADDR;
	localparam logic [5:0] OA = pwm_stage_pkg::OUTCFG_ADDR;
	localparam logic [5:0] MA = pwm_stage_pkg::MASK_ADDR;
	localparam logic [5:0] MI = pwm_stage_pkg::MIC_BASE;
	localparam logic [5:0] RB = pwm_stage_pkg::CMP_RB_LO;
	localparam int         DIVS [4] = '{1, 4, 32, 256};
	logic       clock;
	logic       rst;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] rdata;
	logic       pll_tick;
	logic       io_tick;
	logic [2:0] pin;
	logic [2:0] comp;
	logic [2:0] out_a;
	logic [2:0] out_b;
	logic       fault_irq;
	logic       cycle_end_irq;
	logic       running;
	logic       peek_req;
	logic       rd_late;
	logic       peek_late;
	int         num_errors;
	int         checked;
	note_t      notes [$];
	note_t      cur;
	power_stage_pwm_control uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pll_tick(pll_tick), .io_tick(io_tick),
		.fault_input_pin(pin), .comparator_in(comp), .out_a(out_a), .out_b(out_b),
		.fault_irq(fault_irq), .cycle_end_irq(cycle_end_irq), .running(running));
	fault_source_model #(.IO_GAP(4)) far (.clock(clock), .pll_tick(pll_tick),
		.io_tick(io_tick), .fault_input_pin(pin), .comparator_in(comp));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic give_verdict();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [5:0] a, logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task automatic rd(logic [5:0] a, logic [7:0] e);
		@(posedge clock);
		addr  <= a;
		rd_en <= 1'b1;
		notes.push_back('{$sformatf("reg %h", a), e});
		@(posedge clock);
		rd_en <= 1'b0;
	endtask
	task automatic peek(string w, logic [7:0] e);
		@(posedge clock);
		peek_req <= 1'b1;
		notes.push_back('{w, e});
		@(posedge clock);
		peek_req <= 1'b0;
	endtask
	task automatic cmp(logic [5:0] a, logic [11:0] v);
		wr(a + 6'h01, {4'h0, v[11:8]});
		wr(a, v[7:0]);
	endtask
	task automatic pulse(int n, bit c, int len);
		far.drive(n, c, 1'b1);
		repeat (len) @(posedge clock);
		far.drive(n, c, 1'b0);
		repeat (6) @(posedge clock);
	endtask
	task automatic wait_end();
		int k;
		k = 0;
		// Let the clearing write settle before the flag is looked at again.
		@(negedge clock);
		while (cycle_end_irq !== 1'b1 && k < 10000) begin
			@(negedge clock);
			k++;
		end
	endtask
	function automatic logic [7:0] port_val(string w);
		case (w)
			"out_a":   return {5'h00, out_a};
			"out_b":   return {5'h00, out_b};
			"running": return {7'h00, running};
			"fault":   return {7'h00, fault_irq};
			"end":     return {7'h00, cycle_end_irq};
			default:   return rdata;
		endcase
	endfunction
	// The answer to a read or peek is taken one full cycle after its strobe.
	always @(posedge clock) begin
		rd_late   <= rd_en;
		peek_late <= peek_req;
	end
	always @(negedge clock) begin
		if ((rd_late || peek_late) && notes.size() > 0) begin
			cur = notes.pop_front();
			check(cur.what, port_val(cur.what), cur.val);
		end
	end
	initial begin
		repeat (90000) @(posedge clock);
		num_errors++;
		give_verdict();
	end
	initial begin
		int         m;
		int         p;
		int         e;
		longint     t1;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [5:0] b;
		rst = 1'b1;
		addr = 6'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		peek_req = 1'b0;
		num_errors = 0;
		checked = 0;
		void'($urandom(8213));
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (m = 0; m < 34; m++) rd(6'(m), 8'h00);
		peek("out_a", 8'h07);
		peek("out_b", 8'h07);
		$display("test reset done");
		wr(OA, 8'h20);
		wr(OA, 8'h2C);
		peek("out_a", 8'h07);
		peek("out_b", 8'h07);
		wr(OA, 8'h0C);
		peek("out_a", 8'h00);
		peek("out_b", 8'h00);
		wr(OA, 8'h08);
		peek("out_a", 8'h07);
		peek("out_b", 8'h00);
		wr(OA, 8'hFF);
		rd(OA, 8'h3C);
		wr(OA, 8'h00);
		wr(MA, 8'hFF);
		rd(MA, 8'h0F);
		wr(MI, 8'hFF);
		rd(MI, 8'hFF);
		wr(MI, 8'h00);
		wr(CA, 8'hFF);
		rd(CA, 8'hE3);
		wr(CA, 8'h00);
		wr(6'h21, 8'hFF);
		rd(6'h21, 8'h00);
		$display("test polarity and reserved done");
		for (m = 0; m < 12; m++) begin
			b = 6'((m / 4) * 8 + (m % 4) * 2);
			hi = 8'($urandom);
			lo = 8'($urandom);
			wr(b + 6'h01, hi);
			rd(b + 6'h01, 8'h00);
			wr(b, lo);
			rd(b, lo);
			rd(b + 6'h01, {4'h0, hi[3:0]});
		end
		$display("test compare done");
		cmp(RB, 12'h007);
		wr(MA, 8'h01);
		wr(FA, 8'h0F);
		for (m = 0; m < 8; m++) begin
			p = (m % 4);
			e = 8 * DIVS[p] * ((m >= 4) ? 1 : 4);
			wr(CA, 8'(p * 64 + (m / 4) * 32 + 1));
			wait_end();
			wr(FA, 8'h00);
			peek("end", 8'h01);
			wr(FA, 8'h01);
			wait_end();
			t1 = $time;
			wr(FA, 8'h01);
			wait_end();
			e = int'(($time - t1) / 25) - e;
			check("period", 8'(e > -(8 * DIVS[p]) && e < 8 * DIVS[p] + 3), 8'h01);
			wr(CA, 8'h00);
			wr(FA, 8'h01);
		end
		$display("test prescale done");
		cmp(RB, 12'h0C8);
		wr(CA, 8'h23);
		peek("running", 8'h01);
		repeat (20) @(posedge clock);
		wr(CA, 8'h22);
		peek("running", 8'h01);
		m = 0;
		while (running === 1'b1 && m < 1000) begin
			@(negedge clock);
			m++;
		end
		check("drain", 8'(m > 10 && m < 1000), 8'h01);
		$display("test halt done");
		cmp(RB, 12'hFFF);
		wr(FA, 8'h0F);
		wr(MA, 8'h0E);
		wr(CA, 8'h21);
		for (m = 0; m < 8; m++) begin
			wr(MI, 8'(8'h28 | m));
			pulse(0, 1'b0, 8);
			rd(FA, (m != 0) ? 8'h02 : 8'h00);
			peek("fault", (m != 0) ? 8'h01 : 8'h00);
			if (m >= 6) begin
				peek("running", 8'h00);
				wr(CA, 8'h21);
				peek("running", 8'h01);
			end
			wr(FA, 8'h02);
			peek("fault", 8'h00);
		end
		wr(MA, 8'h00);
		wr(MI + 6'h01, 8'h69);
		pulse(1, 1'b0, 8);
		rd(FA, 8'h00);
		pulse(1, 1'b1, 8);
		rd(FA, 8'h04);
		peek("fault", 8'h00);
		wr(FA, 8'h04);
		far.drive(2, 1'b1, 1'b1);
		wr(MI + 6'h02, 8'h49);
		repeat (8) @(posedge clock);
		rd(FA, 8'h00);
		far.drive(2, 1'b1, 1'b0);
		repeat (8) @(posedge clock);
		rd(FA, 8'h08);
		wr(MI, 8'h39);
		pulse(0, 1'b0, 2);
		rd(FA, 8'h08);
		pulse(0, 1'b0, 8);
		rd(FA, 8'h0A);
		$display("test fault done");
		repeat (4) @(posedge clock);
		give_verdict();
	end
endmodule
`default_nettype wire
